/* design/core_defs.svh */
/*
  Constants of the 8-bit core: opcodes, flag positions, data-space map,
  reset values and cycle counts.
  Assumes it is included by bare name after the core package is compiled.
*/
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH
`define OP_ALU0 4'h0
`define OP_ALU1 4'h1
`define OP_LDI 4'h2
`define OP_SUBI 4'h3
`define OP_ANDI 4'h4
`define OP_ORI 4'h5
`define OP_CPI 4'h6
`define OP_MEMI 4'h7
`define OP_MEMD 4'h8
`define OP_IO 4'h9
`define OP_JMP 4'ha
`define OP_SYS 4'hb
`define SYS_RET 4'h0
`define SYS_RETI 4'h1
`define SYS_SEI 4'h2
`define SYS_CLI 4'h3
`define SYS_LPM 4'h4
`define SYS_FSW 4'h5
`define SYS_SLEEP 4'h6
`define FL_C 0
`define FL_Z 1
`define FL_N 2
`define FL_V 3
`define FL_I 7
`define DS_IO_BASE 16'h0020
`define DS_EXT_BASE 16'h0060
`define DS_STK_LO 16'h005d
`define DS_STK_HI 16'h005e
`define DS_FLAGS 16'h005f
`define STK_RST 16'h0000
`define FLAGS_RST 8'h00
`define IRQ_ENTRY_CYC 3'h4
`define WAKE_CYC 3'h4
`define VEC_STRIDE 16'h0002
`define BLOCKED_BYTE 8'hff
`endif

/* design/core_pkg.sv */
/*
  Types of the 8-bit core: sequencer states and ALU functions.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package core_pkg;
  typedef enum logic [3:0] {S_EXEC, S_W2, S_LOADW, S_TBLW, S_CPUSH, S_IPUSH, S_IRQ,
    S_POP1, S_POP2, S_POP3, S_SLEEP, S_WAKE} state_e;
  typedef enum logic [3:0] {A_ADD, A_SUB, A_AND, A_OR, A_EOR, A_MOV, A_CP,
    A_INC, A_DEC, A_COM, A_LSR} alu_e;
endpackage
`default_nettype wire

/* design/core_top.sv */
/*
  8-bit core: register file, ALU, sequencer, stack, interrupts, flash guard.
  Assumes program and table memory answer combinationally to the address
  outputs, data memory answers a read in the cycle its address stands,
  and interrupt requests come from logic on CLK_I.
*/
`timescale 1ns/10ps
`default_nettype none
`include "core_defs.svh"
module core_top
  import core_pkg::*;
#(
  parameter logic [15:0] BOOT_START = 16'h0c00,
  parameter int NIRQ = 8
)
(
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  output logic [15:0] PM_ADDR_O,
  input wire logic [15:0] PM_DATA_I,
  output logic [15:0] TBL_ADDR_O,
  input wire logic [15:0] TBL_DATA_I,
  output logic [15:0] DM_ADDR_O,
  output logic [7:0] DM_WDATA_O,
  output logic DM_WE_O,
  output logic DM_RE_O,
  input wire logic [7:0] DM_RDATA_I,
  output logic [15:0] FW_ADDR_O,
  output logic [15:0] FW_DATA_O,
  output logic FW_WE_O,
  input wire logic [1:0] LOCK_APP_I,
  input wire logic [1:0] LOCK_BOOT_I,
  input wire logic [NIRQ-1:0] IRQ_I,
  output logic [NIRQ-1:0] IRQ_ACK_O,
  output logic SLEEP_O
);
  logic [1:0] rs_q, rs_d;
  logic rst_n;
  state_e state_q, state_d;
  logic [15:0] pc_q, pc_d, stk_q, stk_d, ir_q, ir_d, ret_q, ret_d, hold_q, hold_d;
  logic [7:0] flags_q, flags_d;
  logic [4:0] dst_q, dst_d;
  logic [1:0] tsel_q, tsel_d;
  logic [2:0] cnt_q, cnt_d;
  logic seid_q, seid_d, dwe_q, dwe_d, dre_q, dre_d, fwe_q, fwe_d, slp_q, slp_d;
  logic [15:0] dma_q, dma_d, tba_q, tba_d, fwa_q, fwa_d, fwd_q, fwd_d;
  logic [7:0] dwd_q, dwd_d;
  logic [NIRQ-1:0] ack_q, ack_d;
  logic [7:0] rf_q [32];
  logic rf_we, acc_en, acc_wr, is_alu, take_irq, ex_reti, ex_sei, ex_io, ex_arith;
  logic [4:0] rf_wa, acc_r, rd;
  logic [7:0] rf_wd, opb, alu_r;
  logic [15:0] acc_a, ir, px, py, pz, zw, vec;
  logic [9:0] alu_o;
  logic [3:0] op;
  alu_e fn;
  logic [NIRQ-1:0] pend, low;
  logic pc_boot, z_boot;

  function automatic logic [9:0] alu(input alu_e f, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic v;
    s = 9'h000;
    v = 1'b0;
    unique case (f)
      A_ADD:
      begin
        s = {1'b0, a} + {1'b0, b};
        v = (a[7] == b[7]) && (s[7] != a[7]);
      end
      A_SUB, A_CP:
      begin
        s = {1'b0, a} - {1'b0, b};
        v = (a[7] != b[7]) && (s[7] != a[7]);
      end
      A_AND: s = {1'b0, a & b};
      A_OR: s = {1'b0, a | b};
      A_EOR: s = {1'b0, a ^ b};
      A_MOV: s = {1'b0, b};
      A_INC: s = {1'b0, a + 8'h01};
      A_DEC: s = {1'b0, a - 8'h01};
      A_COM: s = {1'b1, ~a};
      A_LSR: s = {a[0], 1'b0, a[7:1]};
      default: s = 9'h000;
    endcase
    alu = {v, s};
  endfunction

  function automatic logic [7:0] first_idx(input logic [NIRQ-1:0] p);
    first_idx = 8'h00;
    for (int i = NIRQ - 1; i >= 0; i--)
      if (p[i])
        first_idx = 8'(i);
  endfunction

  assign rst_n = rs_q[1];
  assign ir = (state_q == S_W2) ? ir_q : PM_DATA_I;
  assign op = ir[15:12];
  assign px = {rf_q[27], rf_q[26]};
  assign py = {rf_q[29], rf_q[28]};
  assign pz = {rf_q[31], rf_q[30]};
  assign zw = {1'b0, pz[15:1]};
  assign pc_boot = pc_q >= BOOT_START;
  assign z_boot = zw >= BOOT_START;
  assign pend = IRQ_I & {NIRQ{flags_q[`FL_I]}};
  assign low = pend & (~pend + 1'b1);
  assign vec = ({8'h00, first_idx(pend)} + 16'h0001) * `VEC_STRIDE;

  always_comb
  begin
    rs_d = {rs_q[0], 1'b1};
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rs_q <= 2'b00;
    else if (CE_I)
      rs_q <= rs_d;
  end

  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    stk_d = stk_q;
    flags_d = flags_q;
    ir_d = ir_q;
    ret_d = ret_q;
    hold_d = hold_q;
    dst_d = dst_q;
    tsel_d = tsel_q;
    cnt_d = cnt_q;
    seid_d = seid_q;
    dma_d = dma_q;
    dwd_d = dwd_q;
    dwe_d = 1'b0;
    dre_d = 1'b0;
    tba_d = tba_q;
    fwa_d = fwa_q;
    fwd_d = fwd_q;
    fwe_d = 1'b0;
    ack_d = '0;
    rf_we = 1'b0;
    rf_wa = 5'h00;
    rf_wd = 8'h00;
    acc_en = 1'b0;
    acc_wr = 1'b0;
    acc_a = 16'h0000;
    acc_r = 5'h00;
    is_alu = 1'b0;
    take_irq = 1'b0;
    ex_reti = 1'b0;
    ex_sei = 1'b0;
    ex_io = 1'b0;
    ex_arith = 1'b0;
    fn = A_MOV;
    opb = 8'h00;
    rd = 5'h00;
    alu_o = 10'h000;
    alu_r = 8'h00;
    unique case (state_q)
      S_EXEC:
      begin
        if ((|pend) && !seid_q)
        begin
          take_irq = 1'b1;
          dma_d = stk_q;
          dwd_d = pc_q[7:0];
          dwe_d = 1'b1;
          stk_d = stk_q - 16'h0001;
          ret_d = pc_q;
          hold_d = vec;
          ack_d = {{(NIRQ-1){1'b0}}, 1'b1} << first_idx(pend);
          flags_d[`FL_I] = 1'b0;
          state_d = S_IPUSH;
        end
        else
        begin
          seid_d = 1'b0;
          pc_d = pc_q + 16'h0001;
          unique case (op)
            `OP_ALU0, `OP_ALU1:
            begin
              is_alu = 1'b1;
              rd = ir[9:5];
              opb = rf_q[ir[4:0]];
              fn = ({op[0], ir[11:10]} == 3'h7) ? alu_e'(4'h7 + {2'b00, ir[1:0]})
                : alu_e'({1'b0, op[0], ir[11:10]});
            end
            `OP_LDI, `OP_SUBI, `OP_ANDI, `OP_ORI, `OP_CPI:
            begin
              is_alu = 1'b1;
              rd = {1'b1, ir[11:8]};
              opb = ir[7:0];
              fn = (op == `OP_LDI) ? A_MOV : (op == `OP_SUBI) ? A_SUB
                : (op == `OP_ANDI) ? A_AND : (op == `OP_ORI) ? A_OR : A_CP;
            end
            `OP_MEMI:
            begin
              acc_en = 1'b1;
              acc_wr = ir[11];
              acc_r = ir[8:4];
              acc_a = ((ir[10:9] == 2'h0) ? px : (ir[10:9] == 2'h1) ? py : pz)
                + {12'h000, ir[3:0]};
            end
            `OP_MEMD, `OP_JMP:
            begin
              ir_d = ir;
              state_d = S_W2;
            end
            `OP_IO:
            begin
              ex_io = 1'b1;
              acc_en = 1'b1;
              acc_wr = ir[11];
              acc_r = ir[4:0];
              acc_a = {10'h000, ir[10:5]} + `DS_IO_BASE;
            end
            `OP_SYS:
            begin
              ir_d = ir;
              if (ir[11:8] == `SYS_RET || ir[11:8] == `SYS_RETI)
              begin
                ex_reti = ir[11:8] == `SYS_RETI;
                dma_d = stk_q + 16'h0001;
                dre_d = 1'b1;
                stk_d = stk_q + 16'h0001;
                state_d = S_POP1;
              end
              else if (ir[11:8] == `SYS_SEI)
              begin
                ex_sei = 1'b1;
                flags_d[`FL_I] = 1'b1;
                seid_d = 1'b1;
              end
              else if (ir[11:8] == `SYS_CLI)
                flags_d[`FL_I] = 1'b0;
              else if (ir[11:8] == `SYS_LPM)
              begin
                tba_d = zw;
                tsel_d = {z_boot ? (!pc_boot && LOCK_BOOT_I[1]) : (pc_boot && LOCK_APP_I[1]),
                  pz[0]};
                dst_d = ir[4:0];
                state_d = S_TBLW;
              end
              else if (ir[11:8] == `SYS_FSW)
              begin
                fwa_d = zw;
                fwd_d = {rf_q[1], rf_q[0]};
                fwe_d = z_boot ? !LOCK_BOOT_I[0] : (pc_boot && !LOCK_APP_I[0]);
              end
              else if (ir[11:8] == `SYS_SLEEP)
                state_d = S_SLEEP;
            end
            default: pc_d = pc_q + 16'h0001;
          endcase
        end
      end
      S_W2:
      begin
        pc_d = pc_q + 16'h0001;
        state_d = S_EXEC;
        if (ir_q[15:12] == `OP_MEMD)
        begin
          acc_en = 1'b1;
          acc_wr = ir_q[11];
          acc_r = ir_q[8:4];
          acc_a = PM_DATA_I;
        end
        else if (!ir_q[10] || flags_q[ir_q[2:0]] == ir_q[9])
        begin
          pc_d = PM_DATA_I;
          if (ir_q[11])
          begin
            pc_d = pc_q + 16'h0001;
            dma_d = stk_q;
            dwd_d = pc_d[7:0];
            dwe_d = 1'b1;
            stk_d = stk_q - 16'h0001;
            ret_d = pc_d;
            hold_d = PM_DATA_I;
            state_d = S_CPUSH;
          end
        end
      end
      S_CPUSH, S_IPUSH:
      begin
        dma_d = stk_q;
        dwd_d = ret_q[15:8];
        dwe_d = 1'b1;
        stk_d = stk_q - 16'h0001;
        pc_d = hold_q;
        cnt_d = `IRQ_ENTRY_CYC - 3'h2;
        state_d = (state_q == S_IPUSH) ? S_IRQ : S_EXEC;
      end
      S_IRQ, S_WAKE:
      begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1)
          state_d = S_EXEC;
      end
      S_LOADW:
      begin
        rf_we = 1'b1;
        rf_wa = dst_q;
        rf_wd = DM_RDATA_I;
        state_d = S_EXEC;
      end
      S_TBLW:
      begin
        rf_we = 1'b1;
        rf_wa = dst_q;
        rf_wd = tsel_q[1] ? `BLOCKED_BYTE : (tsel_q[0] ? TBL_DATA_I[15:8] : TBL_DATA_I[7:0]);
        state_d = S_EXEC;
      end
      S_POP1:
      begin
        hold_d[15:8] = DM_RDATA_I;
        dma_d = stk_q + 16'h0001;
        dre_d = 1'b1;
        stk_d = stk_q + 16'h0001;
        state_d = S_POP2;
      end
      S_POP2:
      begin
        pc_d = {hold_q[15:8], DM_RDATA_I};
        state_d = S_POP3;
      end
      S_POP3:
      begin
        state_d = S_EXEC;
        if (ir_q[11:8] == `SYS_RETI)
        begin
          flags_d[`FL_I] = 1'b1;
          seid_d = 1'b1;
        end
      end
      S_SLEEP:
      begin
        cnt_d = `WAKE_CYC;
        if (|pend)
          state_d = S_WAKE;
      end
      default: state_d = S_EXEC;
    endcase
    if (is_alu)
    begin
      alu_o = alu(fn, rf_q[rd], opb);
      alu_r = alu_o[7:0];
      if (fn != A_CP)
      begin
        rf_we = 1'b1;
        rf_wa = rd;
        rf_wd = alu_r;
      end
      if (fn != A_MOV)
      begin
        ex_arith = 1'b1;
        flags_d[`FL_C] = alu_o[8];
        flags_d[`FL_Z] = alu_r == 8'h00;
        flags_d[`FL_N] = alu_r[7];
        flags_d[`FL_V] = alu_o[9];
      end
    end
    if (acc_en)
    begin
      if (acc_a < `DS_IO_BASE)
      begin
        rf_we = 1'b1;
        rf_wa = acc_wr ? acc_a[4:0] : acc_r;
        rf_wd = acc_wr ? rf_q[acc_r] : rf_q[acc_a[4:0]];
      end
      else if (acc_a == `DS_STK_LO || acc_a == `DS_STK_HI || acc_a == `DS_FLAGS)
      begin
        rf_we = !acc_wr;
        rf_wa = acc_r;
        rf_wd = (acc_a == `DS_STK_LO) ? stk_q[7:0] : (acc_a == `DS_STK_HI) ? stk_q[15:8]
          : flags_q;
        if (acc_wr && acc_a == `DS_STK_LO)
          stk_d[7:0] = rf_q[acc_r];
        else if (acc_wr && acc_a == `DS_STK_HI)
          stk_d[15:8] = rf_q[acc_r];
        else if (acc_wr)
          flags_d = rf_q[acc_r];
      end
      else
      begin
        dma_d = acc_a;
        dwd_d = rf_q[acc_r];
        dwe_d = acc_wr;
        dre_d = !acc_wr;
        dst_d = acc_r;
        if (!acc_wr)
          state_d = S_LOADW;
      end
    end
    slp_d = state_d == S_SLEEP;
  end

  always_ff @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_EXEC;
      pc_q <= 16'h0000;
      stk_q <= `STK_RST;
      flags_q <= `FLAGS_RST;
      {ir_q, ret_q, hold_q, dma_q, tba_q, fwa_q, fwd_q} <= '0;
      {dst_q, tsel_q, cnt_q, dwd_q} <= '0;
      {seid_q, dwe_q, dre_q, fwe_q, slp_q} <= '0;
      ack_q <= '0;
      for (int i = 0; i < 32; i++)
        rf_q[i] <= 8'h00;
    end
    else if (CE_I)
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      stk_q <= stk_d;
      flags_q <= flags_d;
      {ir_q, ret_q, hold_q, dma_q, tba_q, fwa_q, fwd_q} <= {ir_d, ret_d, hold_d, dma_d,
        tba_d, fwa_d, fwd_d};
      {dst_q, tsel_q, cnt_q, dwd_q} <= {dst_d, tsel_d, cnt_d, dwd_d};
      {seid_q, dwe_q, dre_q, fwe_q, slp_q} <= {seid_d, dwe_d, dre_d, fwe_d, slp_d};
      ack_q <= ack_d;
      if (rf_we)
        rf_q[rf_wa] <= rf_wd;
    end
  end

  assign PM_ADDR_O = pc_q;
  assign TBL_ADDR_O = tba_q;
  assign DM_ADDR_O = dma_q;
  assign DM_WDATA_O = dwd_q;
  assign DM_WE_O = dwe_q;
  assign DM_RE_O = dre_q;
  assign FW_ADDR_O = fwa_q;
  assign FW_DATA_O = fwd_q;
  assign FW_WE_O = fwe_q;
  assign IRQ_ACK_O = ack_q;
  assign SLEEP_O = slp_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n || !CE_I);

  rf_write_a: assert property (rf_we |=> rf_q[$past(rf_wa)] == $past(rf_wd))
    else $error("register file write lost");
  alu_wb_a: assert property (is_alu && fn != A_CP |=> rf_q[$past(rd)] == $past(alu_r))
    else $error("alu result not written back");
  flag_z_a: assert property (ex_arith |=> flags_q[`FL_Z] == ($past(alu_r) == 8'h00))
    else $error("zero flag wrong");
  gie_gate_a: assert property (take_irq |-> flags_q[`FL_I])
    else $error("interrupt taken while disabled");
  irq_prio_a: assert property (take_irq |=> IRQ_ACK_O == $past(low))
    else $error("wrong interrupt chosen");
  irq_entry_a: assert property (take_irq |=> state_q == S_IPUSH && DM_WE_O ##1
    (state_q == S_IRQ)[*2] ##1 state_q == S_EXEC && pc_q == $past(hold_q, 3))
    else $error("interrupt entry timing wrong");
  reti_pop_a: assert property (ex_reti |-> ##4 state_q == S_EXEC &&
    flags_q[`FL_I] && stk_q == $past(stk_q, 4) + 16'h0002)
    else $error("return from interrupt wrong");
  sei_delay_a: assert property (ex_sei |=> !take_irq)
    else $error("interrupt before following instruction");
  wake_delay_a: assert property (state_q == S_SLEEP && state_d == S_WAKE |=>
    (state_q == S_WAKE)[*4] ##1 state_q == S_EXEC)
    else $error("wake from sleep timing wrong");
  fsw_boot_a: assert property (FW_WE_O && FW_ADDR_O < BOOT_START |->
    $past(pc_q) >= BOOT_START)
    else $error("application flash written from outside boot");
  io_range_a: assert property (ex_io |=> !(DM_WE_O || DM_RE_O) ||
    DM_ADDR_O < `DS_EXT_BASE)
    else $error("direct I/O reached extended region");

  irq_c: cover property (take_irq);
  call_c: cover property (state_q == S_CPUSH);
  tbl_c: cover property (state_q == S_TBLW);
  wake_c: cover property (state_q == S_WAKE ##4 take_irq);
endmodule
`default_nettype wire

/* sim/core_mem_model.sv */
/*
  Far-side model of the core: program flash, data memory, flash-write record
  and pending-interrupt latches.
  Assumes the core's strobes and addresses are registers on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module core_mem_model #(
  parameter int NIRQ = 8
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] pm_addr_i,
  output logic [15:0] pm_data_o,
  input wire logic [15:0] tbl_addr_i,
  output logic [15:0] tbl_data_o,
  input wire logic [15:0] dm_addr_i,
  input wire logic [7:0] dm_wdata_i,
  input wire logic dm_we_i,
  input wire logic dm_re_i,
  output logic [7:0] dm_rdata_o,
  input wire logic [15:0] fw_addr_i,
  input wire logic [15:0] fw_data_i,
  input wire logic fw_we_i,
  input wire logic [NIRQ-1:0] irq_set_i,
  input wire logic [NIRQ-1:0] irq_ack_i,
  output logic [NIRQ-1:0] irq_o
);
  logic [15:0] prog [0:4095];
  logic [7:0] dmem [0:4095];
  logic [7:0] junk_q = 8'h3c;
  logic [NIRQ-1:0] first_ack_q;
  int fw_cnt = 0;
  logic [15:0] fw_addr_q;
  logic [15:0] fw_data_q;
  assign pm_data_o = prog[pm_addr_i[11:0]];
  assign tbl_data_o = prog[tbl_addr_i[11:0]];
  // outside a read strobe the bus carries a changing pattern, not the last byte
  assign dm_rdata_o = dm_re_i ? dmem[dm_addr_i[11:0]] : junk_q;
  always @(posedge clk_i)
  begin
    junk_q <= junk_q + 8'h5b;
    if (dm_we_i)
    begin
      dmem[dm_addr_i[11:0]] <= dm_wdata_i;
    end
    if (fw_we_i)
    begin
      fw_cnt <= fw_cnt + 1;
      fw_addr_q <= fw_addr_i;
      fw_data_q <= fw_data_i;
    end
  end
  // requests stand until acknowledged, as peripheral flags do
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_o <= '0;
      first_ack_q <= '0;
    end
    else
    begin
      irq_o <= (irq_o & ~irq_ack_i) | irq_set_i;
      if (first_ack_q == '0)
      begin
        first_ack_q <= irq_ack_i;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
/*
  Testbench of the core: small programs run from the model's flash, results
  read back from its data memory and flash-write record.
  Assumes core_top and core_mem_model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [1:0] lock_app = 2'h0;
  logic [1:0] lock_boot = 2'h0;
  logic [7:0] irq_set = 8'h00;
  logic [15:0] pm_addr, pm_data, tbl_addr, tbl_data, dm_addr, fw_addr, fw_data;
  logic [7:0] dm_wdata, dm_rdata, irq, ack;
  logic dm_we, dm_re, fw_we, sleep;
  int bad_count = 0;
  int checked = 0;
  int pc_w = 0;
  int slept = 0;
  logic [15:0] halt_at;
  always #50 clk = ~clk;
  // cycles spent with the sleep output high, per program
  always @(posedge clk)
  begin
    if (sleep === 1'b1)
      slept <= slept + 1;
  end
  core_top #(.BOOT_START(16'h0100), .NIRQ(8)) core_top_inst (.CLK_I(clk), .RST_N_I(rst_n),
    .CE_I(ce), .PM_ADDR_O(pm_addr), .PM_DATA_I(pm_data), .TBL_ADDR_O(tbl_addr),
    .TBL_DATA_I(tbl_data), .DM_ADDR_O(dm_addr), .DM_WDATA_O(dm_wdata), .DM_WE_O(dm_we),
    .DM_RE_O(dm_re), .DM_RDATA_I(dm_rdata), .FW_ADDR_O(fw_addr), .FW_DATA_O(fw_data),
    .FW_WE_O(fw_we), .LOCK_APP_I(lock_app), .LOCK_BOOT_I(lock_boot), .IRQ_I(irq),
    .IRQ_ACK_O(ack), .SLEEP_O(sleep));
  core_mem_model #(.NIRQ(8)) core_mem_model_inst (.clk_i(clk), .rst_n_i(rst_n),
    .pm_addr_i(pm_addr), .pm_data_o(pm_data), .tbl_addr_i(tbl_addr), .tbl_data_o(tbl_data),
    .dm_addr_i(dm_addr), .dm_wdata_i(dm_wdata), .dm_we_i(dm_we), .dm_re_i(dm_re),
    .dm_rdata_o(dm_rdata), .fw_addr_i(fw_addr), .fw_data_i(fw_data), .fw_we_i(fw_we),
    .irq_set_i(irq_set), .irq_ack_i(ack), .irq_o(irq));
  task automatic wrap_up();
    if (bad_count == 0 && checked > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rd(input logic [15:0] a);
    return core_mem_model_inst.dmem[a[11:0]];
  endfunction
  function automatic logic [15:0] ldi(input int d, input logic [7:0] k);
    return {4'h2, 4'(d - 16), k};
  endfunction
  function automatic logic [15:0] rr(input int c, input int d, input int r);
    return {3'h0, 1'(c >> 2), 2'(c), 5'(d), 5'(r)};
  endfunction
  function automatic logic [15:0] io(input int o, input int a, input int r);
    return {4'h9, 1'(o), 6'(a), 5'(r)};
  endfunction
  function automatic logic [15:0] sys(input int k, input int r);
    return {4'hb, 4'(k), 3'h0, 5'(r)};
  endfunction
  task automatic put(input logic [15:0] w);
    core_mem_model_inst.prog[pc_w] = w;
    pc_w++;
  endtask
  task automatic mem(input logic store, input int r, input logic [15:0] a);
    put({4'h8, store, 2'h0, 5'(r), 4'h0});
    put(a);
  endtask
  task automatic jmp(input logic [2:0] ccv, input logic [2:0] fl, input logic [15:0] t);
    put({4'ha, ccv, 6'h0, fl});
    put(t);
  endtask
  task automatic halt();
    halt_at = 16'(pc_w);
    jmp(3'h0, 3'h0, halt_at);
  endtask
  task automatic stk_init();
    put(ldi(16, 8'h00));
    put(io(1, 'h3d, 16));
    put(ldi(16, 8'h04));
    put(io(1, 'h3e, 16));
  endtask
  task automatic fresh(input logic [1:0] la, input logic [1:0] lb);
    @(posedge clk);
    rst_n <= 1'b0;
    lock_app <= la;
    lock_boot <= lb;
    for (int i = 0; i < 4096; i++)
    begin
      core_mem_model_inst.prog[i] = 16'hc000;
      core_mem_model_inst.dmem[i] = 8'h00;
    end
    core_mem_model_inst.prog[16'h40] = 16'hbeef;
    core_mem_model_inst.fw_cnt = 0;
    pc_w = 0;
    slept = 0;
  endtask
  task automatic start();
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic finish_at(input logic [15:0] a, input int extra);
    int n;
    n = 0;
    while (pm_addr !== a && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk16(pm_addr, a);
    repeat (extra) @(negedge clk);
  endtask
  task automatic t_alu();
    fresh(2'h0, 2'h0);
    put(ldi(16, 8'h3c));
    put(ldi(17, 8'hc5));
    put(rr(0, 16, 17));
    mem(0, 20, 16'h005f);
    put(rr(1, 17, 17));
    mem(0, 21, 16'h005f);
    put(rr(5, 5, 16));
    mem(0, 22, 16'h0005);
    put(rr(7, 16, 2));
    mem(1, 16, 16'h0100);
    put(rr(7, 16, 3));
    mem(1, 16, 16'h0101);
    for (int i = 0; i < 4; i++)
    begin
      mem(1, 19 + (i + 1) % 4, 16'h0102 + 16'(i));
    end
    halt();
    start();
    finish_at(halt_at, 4);
    chk8(rd(16'h0100), 8'hfe);
    chk8(rd(16'h0101), 8'h7f);
    chk8(rd(16'h0102), 8'h01);
    chk8(rd(16'h0103), 8'h02);
    chk8(rd(16'h0104), 8'h01);
    chk8(rd(16'h0105), 8'h00);
  endtask
  task automatic t_ptr();
    fresh(2'h0, 2'h0);
    core_mem_model_inst.dmem[16'h245] = 8'h5c;
    for (int i = 0; i < 6; i++)
    begin
      put(ldi(26 + i, 8'(i % 2 ? 2 : 16 * i)));
    end
    put(ldi(16, 8'ha1));
    put({4'h7, 1'b1, 2'h0, 5'd16, 4'h3});
    put({4'h7, 1'b1, 2'h1, 5'd16, 4'hf});
    put({4'h7, 1'b0, 2'h2, 5'd17, 4'h5});
    mem(1, 17, 16'h0110);
    halt();
    start();
    // a low clock enable must hold the core at the third instruction
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    repeat (3) @(negedge clk);
    chk16(pm_addr, 16'h0002);
    @(posedge clk);
    ce <= 1'b1;
    finish_at(halt_at, 4);
    chk8(rd(16'h0203), 8'ha1);
    chk8(rd(16'h022f), 8'ha1);
    chk8(rd(16'h0110), 8'h5c);
  endtask
  task automatic t_lpm();
    fresh(2'h0, 2'h0);
    put(ldi(30, 8'h81));
    put(ldi(31, 8'h00));
    put(sys(4, 20));
    put(ldi(30, 8'h80));
    put(sys(4, 21));
    mem(1, 20, 16'h0120);
    mem(1, 21, 16'h0121);
    halt();
    start();
    finish_at(halt_at, 4);
    chk8(rd(16'h0120), 8'hbe);
    chk8(rd(16'h0121), 8'hef);
  endtask
  task automatic t_io();
    fresh(2'h0, 2'h0);
    core_mem_model_inst.dmem[16'h31] = 8'h4b;
    put(ldi(16, 8'h77));
    put(io(1, 'h10, 16));
    put(io(0, 'h11, 17));
    mem(1, 16, 16'h0080);
    put(ldi(18, 8'h34));
    put(ldi(19, 8'h12));
    put(io(1, 'h3d, 18));
    put(io(1, 'h3e, 19));
    put(io(0, 'h3d, 20));
    put(io(0, 'h3e, 21));
    mem(1, 17, 16'h0130);
    mem(1, 20, 16'h0131);
    mem(1, 21, 16'h0132);
    halt();
    start();
    finish_at(halt_at, 4);
    chk8(rd(16'h0030), 8'h77);
    chk8(rd(16'h0130), 8'h4b);
    chk8(rd(16'h0080), 8'h77);
    chk8(rd(16'h0131), 8'h34);
    chk8(rd(16'h0132), 8'h12);
  endtask
  task automatic t_call();
    fresh(2'h0, 2'h0);
    stk_init();
    jmp(3'h4, 3'h0, 16'h0f00);
    put(ldi(18, 8'h05));
    put(rr(6, 18, 18));
    jmp(3'h3, 3'h0, 16'h0f20);
    jmp(3'h3, 3'h1, 16'h0f10);
    pc_w = 'h0f00;
    put(ldi(17, 8'h99));
    mem(1, 17, 16'h0140);
    put(sys(0, 0));
    for (int i = 0; i < 2; i++)
    begin
      pc_w = i ? 'h0f10 : 'h0f20;
      put(ldi(19, i ? 8'h33 : 8'hee));
      mem(1, 19, 16'h0141);
      halt();
    end
    start();
    finish_at(16'h0f14, 4);
    chk8(rd(16'h0140), 8'h99);
    chk8(rd(16'h0141), 8'h33);
    chk8(rd(16'h0400), 8'h06);
    chk8(rd(16'h03ff), 8'h00);
  endtask
  task automatic t_irq();
    fresh(2'h0, 2'h0);
    jmp(3'h0, 3'h0, 16'h0020);
    for (int i = 0; i < 2; i++)
    begin
      pc_w = i ? 12 : 4;
      jmp(3'h0, 3'h0, i ? 16'h0038 : 16'h0030);
      pc_w = i ? 'h38 : 'h30;
      mem(1, 24, 16'h0150 + 16'(i));
      put(rr(7, 24, 0));
      put(sys(1, 0));
    end
    pc_w = 'h20;
    stk_init();
    put(sys(2, 0));
    put(ldi(24, 8'h01));
    put(sys(6, 0));
    halt();
    start();
    irq_set <= 8'h22;
    @(posedge clk);
    irq_set <= 8'h00;
    finish_at(16'h003b, 8);
    chk8(rd(16'h0150), 8'h01);
    chk8(rd(16'h0151), 8'h02);
    chk8(core_mem_model_inst.first_ack_q, 8'h02);
    chk8(rd(16'h0400), 8'h27);
    chk8(8'(slept), 8'h01);
    chk8(rd(16'h03fe), 8'h00);
  endtask
  task automatic t_fw(input logic bt, input logic [1:0] la, input logic [1:0] lb,
    input logic [15:0] z, input logic wr, input logic [7:0] lp);
    fresh(la, lb);
    jmp(3'h0, 3'h0, bt ? 16'h0100 : 16'h0020);
    pc_w = bt ? 'h100 : 'h20;
    put(ldi(16, 8'h5a));
    put(ldi(17, 8'ha5));
    put(rr(5, 0, 16));
    put(rr(5, 1, 17));
    put(ldi(30, z[7:0]));
    put(ldi(31, z[15:8]));
    put(sys(5, 0));
    put(ldi(30, 8'h81));
    put(ldi(31, 8'h00));
    put(sys(4, 20));
    mem(1, 20, 16'h0160);
    halt();
    start();
    finish_at(halt_at, 4);
    chk8(8'(core_mem_model_inst.fw_cnt), {7'h0, wr});
    chk8(rd(16'h0160), lp);
    if (wr)
    begin
      chk16(core_mem_model_inst.fw_addr_q, z >> 1);
      chk16(core_mem_model_inst.fw_data_q, 16'ha55a);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    t_alu();
    t_ptr();
    t_lpm();
    t_io();
    t_call();
    t_irq();
    t_fw(1'b0, 2'h0, 2'h0, 16'h00a0, 1'b0, 8'hbe);
    t_fw(1'b1, 2'h0, 2'h0, 16'h00a0, 1'b1, 8'hbe);
    t_fw(1'b1, 2'h1, 2'h0, 16'h00a0, 1'b0, 8'hbe);
    t_fw(1'b1, 2'h2, 2'h0, 16'h00a0, 1'b1, 8'hff);
    t_fw(1'b1, 2'h0, 2'h1, 16'h0300, 1'b0, 8'hbe);
    t_fw(1'b1, 2'h0, 2'h0, 16'h0300, 1'b1, 8'hbe);
    wrap_up();
  end
  // a dozen short programs need well under 5000 cycles of 100 ns
  initial
  begin
    #500000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
